// ---- event_msg_pkg.sv ----
/*
 holds offsets, reset values, field layouts and carrier structs for the page request
 event message address block.
 assumes an axi4-lite master with 32-bit data and byte addresses.
*/
package event_msg_pkg;
   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [11:0] data_offset      = 12'h0_0E4;
   localparam logic [11:0] addr_low_offset  = 12'h0_0E8;
   localparam logic [11:0] addr_high_offset = 12'h0_0EC;
   localparam logic [11:0] control_offset   = 12'h0_0E0;
   localparam logic [11:0] irq_status_offset = 12'h0_0F0;
   localparam logic [11:0] irq_mask_offset  = 12'h0_0F4;
   localparam int          addr_bits        = 12;
   localparam int          reg_count        = 6;
   localparam logic [2:0]  idx_control      = 3'h0;
   localparam logic [2:0]  idx_data         = 3'h1;
   localparam logic [2:0]  idx_low          = 3'h2;
   localparam logic [2:0]  idx_high         = 3'h3;
   localparam logic [2:0]  idx_status       = 3'h4;
   localparam logic [2:0]  idx_mask         = 3'h5;
   localparam logic [2:0]  idx_none         = 3'h7;

   // ------------------------------------------------------------
   // reset values and fields
   // ------------------------------------------------------------
   localparam logic [31:0] zero_reset       = 32'h0000_0000;
   localparam logic [31:0] low_keep_mask    = 32'hFFFF_FFFC;
   localparam logic [31:0] data16_mask      = 32'h0000_FFFF;
   localparam logic [31:0] control_reset    = 32'h8000_0000;
   localparam int          mask_bit         = 31;
   localparam int          pending_bit      = 30;
   localparam logic [31:0] control_rw_mask  = 32'h8000_0000;
   localparam logic [31:0] irq_bits_mask    = 32'h0000_0001;
   localparam int          sent_event_bit   = 0;
   localparam logic [1:0]  resp_okay        = 2'b00;
   localparam logic [1:0]  resp_slverr      = 2'b10;

   // ------------------------------------------------------------
   // carrier for the outgoing message write
   // ------------------------------------------------------------
   typedef struct packed
   {
      logic [63:0] address;
      logic [31:0] data;
   } message_s;

   typedef enum logic [1:0]
   {
      msg_idle    = 2'b00,
      msg_request = 2'b01
   } msg_state_e;
endpackage

// ---- event_msg_regs.sv ----
/*
 holds the page request event message registers behind an axi4-lite slave, and the
 message generator that issues the event interrupt write.
 assumes one clock, a synchronous active-low reset, and a message sink that raises
 msg_ready when it takes a message.
*/
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
module event_msg_regs
#(
   parameter bit page_request_supported  = 1'b1,
   parameter bit extended_mode_supported = 1'b1,
   parameter bit wide_data_supported     = 1'b0
)
(
   input  wire logic                      aclk,
   input  wire logic                      aresetn,
   input  wire logic [11:0]               s_axi_awaddr,
   input  wire logic                      s_axi_awvalid,
   output logic                           s_axi_awready,
   input  wire logic [31:0]               s_axi_wdata,
   input  wire logic [3:0]                s_axi_wstrb,
   input  wire logic                      s_axi_wvalid,
   output logic                           s_axi_wready,
   output logic      [1:0]                s_axi_bresp,
   output logic                           s_axi_bvalid,
   input  wire logic                      s_axi_bready,
   input  wire logic [11:0]               s_axi_araddr,
   input  wire logic                      s_axi_arvalid,
   output logic                           s_axi_arready,
   output logic      [31:0]               s_axi_rdata,
   output logic      [1:0]                s_axi_rresp,
   output logic                           s_axi_rvalid,
   input  wire logic                      s_axi_rready,
   input  wire logic                      page_event,
   output event_msg_pkg::message_s        msg,
   output logic                           msg_valid,
   input  wire logic                      msg_ready,
   output logic                           irq
);
   // ------------------------------------------------------------
   // write channel capture
   // ------------------------------------------------------------
   logic        aw_held;
   logic        w_held;
   logic [11:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        do_write;
   logic [2:0]  write_idx;
   logic [2:0]  read_idx;

   // decoding shared by both address channels
   function automatic logic [2:0] decode(input logic [11:0] addr);
      case (addr)
         event_msg_pkg::control_offset:    decode = event_msg_pkg::idx_control;
         event_msg_pkg::data_offset:       decode = event_msg_pkg::idx_data;
         event_msg_pkg::addr_low_offset:   decode = event_msg_pkg::idx_low;
         event_msg_pkg::addr_high_offset:  decode = event_msg_pkg::idx_high;
         event_msg_pkg::irq_status_offset: decode = event_msg_pkg::idx_status;
         event_msg_pkg::irq_mask_offset:   decode = event_msg_pkg::idx_mask;
         default:                          decode = event_msg_pkg::idx_none;
      endcase
   endfunction

   // channels are taken in either order and held until the response goes out
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign do_write      = aw_held && w_held && !s_axi_bvalid;
   assign write_idx     = decode(aw_addr);
   assign read_idx      = decode(s_axi_araddr);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held      <= 1'b0;
         w_held       <= 1'b0;
         aw_addr      <= 12'h000;
         w_data       <= event_msg_pkg::zero_reset;
         w_strb       <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= event_msg_pkg::resp_okay;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_write)
         begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (write_idx == event_msg_pkg::idx_none) ?
                            event_msg_pkg::resp_slverr : event_msg_pkg::resp_okay;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // register words
   // ------------------------------------------------------------
   logic [31:0] word [event_msg_pkg::reg_count];
   logic [31:0] keep [event_msg_pkg::reg_count];
   logic [31:0] rst_val [event_msg_pkg::reg_count];

   // data is reserved without page request support, upper half only with wide data
   assign keep[event_msg_pkg::idx_data] = !page_request_supported ? event_msg_pkg::zero_reset :
      wide_data_supported ? ~event_msg_pkg::zero_reset : event_msg_pkg::data16_mask;
   // low address: bits 1:0 never stored all reserved without support
   assign keep[event_msg_pkg::idx_low] = page_request_supported ?
      event_msg_pkg::low_keep_mask : event_msg_pkg::zero_reset;
   // high address full 32 bits, or reserved without extended mode
   assign keep[event_msg_pkg::idx_high] = extended_mode_supported ?
      ~event_msg_pkg::zero_reset : event_msg_pkg::zero_reset;
   assign keep[event_msg_pkg::idx_control] = event_msg_pkg::control_rw_mask;
   assign keep[event_msg_pkg::idx_mask]    = event_msg_pkg::irq_bits_mask;
   // status slot has a reg_word with a zero keep mask, so it stays unwritable; reads show irq_status instead
   assign keep[event_msg_pkg::idx_status]  = event_msg_pkg::zero_reset;

   genvar r;
   generate
      for (r = 0; r < event_msg_pkg::reg_count; r++)
      begin : g_reg
         assign rst_val[r] = (r == event_msg_pkg::idx_control) ?
            event_msg_pkg::control_reset : event_msg_pkg::zero_reset;
         reg_word u_word
         (
            .aclk        (aclk),
            .aresetn     (aresetn),
            .write_en    (do_write && (write_idx == 3'(r))),
            .write_strb  (w_strb),
            .write_data  (w_data),
            .keep_mask   (keep[r]),
            .reset_value (rst_val[r]),
            .value       (word[r])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // message generator
   // ------------------------------------------------------------
   event_msg_pkg::msg_state_e state;
   event_msg_pkg::msg_state_e next_state;
   logic        interrupt_mask;
   logic        interrupt_pending;
   logic        event_prev;
   logic        event_rise;
   logic        sent_pulse;
   logic [31:0] irq_status;
   logic        status_read;

   assign interrupt_mask = word[event_msg_pkg::idx_control][event_msg_pkg::mask_bit];
   assign event_rise     = page_event && !event_prev;
   assign sent_pulse     = msg_valid && msg_ready;
   assign msg_valid      = (state == event_msg_pkg::msg_request);
   // no message is raised while masked; it waits as pending until unmasked
   assign next_state = (state == event_msg_pkg::msg_idle) ?
      ((interrupt_pending && !interrupt_mask && page_request_supported) ?
       event_msg_pkg::msg_request : event_msg_pkg::msg_idle) :
      (msg_ready ? event_msg_pkg::msg_idle : event_msg_pkg::msg_request);

   // pending sets on a new event; a new event wins over the send that clears it
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state             <= event_msg_pkg::msg_idle;
         event_prev        <= 1'b0;
         interrupt_pending <= 1'b0;
      end
      else
      begin
         state      <= next_state;
         event_prev <= page_event;
         if (event_rise)
            interrupt_pending <= 1'b1;
         else if (sent_pulse)
            interrupt_pending <= 1'b0;
      end
   end

   // payload frozen while the request is offered; destination from both words
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         msg <= '0;
      else if (state == event_msg_pkg::msg_idle)
      begin
         msg.address <= {word[event_msg_pkg::idx_high],
                         word[event_msg_pkg::idx_low] & event_msg_pkg::low_keep_mask};
         msg.data    <= word[event_msg_pkg::idx_data];
      end
   end

   // ------------------------------------------------------------
   // interrupt status, read clears, set wins
   // ------------------------------------------------------------
   assign status_read = s_axi_arvalid && s_axi_arready &&
                        (read_idx == event_msg_pkg::idx_status);
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         irq_status <= event_msg_pkg::zero_reset;
      else if (sent_pulse)
         irq_status[event_msg_pkg::sent_event_bit] <= 1'b1;
      else if (status_read)
         irq_status <= event_msg_pkg::zero_reset;
   end
   assign irq = |(irq_status & word[event_msg_pkg::idx_mask]);

   // ------------------------------------------------------------
   // read channel
   // ------------------------------------------------------------
   logic [31:0] read_word;
   assign s_axi_arready = !s_axi_rvalid;
   // pending bit reflects live state, status read shows the sticky word
   assign read_word =
      (read_idx == event_msg_pkg::idx_control) ?
         (word[event_msg_pkg::idx_control] |
          ({31'h0000_0000, interrupt_pending} << event_msg_pkg::pending_bit)) :
      (read_idx == event_msg_pkg::idx_status) ? irq_status :
      (read_idx == event_msg_pkg::idx_none) ? event_msg_pkg::zero_reset :
      word[read_idx];

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= event_msg_pkg::zero_reset;
         s_axi_rresp  <= event_msg_pkg::resp_okay;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= read_word;
         s_axi_rresp  <= (read_idx == event_msg_pkg::idx_none) ?
                         event_msg_pkg::resp_slverr : event_msg_pkg::resp_okay;
      end
      else if (s_axi_rvalid && s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end
endmodule

// ---- event_msg_regs_sva.sv ----
/* checker: read answers and the outgoing event message.
   assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ps
module event_msg_regs_sva
(
   input wire logic                    aclk,
   input wire logic                    aresetn,
   input wire logic [11:0]             s_axi_araddr,
   input wire logic                    s_axi_arvalid,
   input wire logic                    s_axi_arready,
   input wire logic [31:0]             s_axi_rdata,
   input wire logic [1:0]              s_axi_rresp,
   input wire logic                    s_axi_rvalid,
   input wire logic                    s_axi_rready,
   input wire event_msg_pkg::message_s msg,
   input wire logic                    msg_valid,
   input wire logic                    msg_ready
);
   logic [11:0] last_ar;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // ----------------------------------------
   // read address kept to judge the answer
   // ----------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         last_ar <= 12'h000;
      else if (s_axi_arvalid && s_axi_arready)
         last_ar <= s_axi_araddr;
   end
   a_low_aligned: assert property (
      s_axi_rvalid && last_ar == 12'h0E8 |-> s_axi_rdata[1:0] == 2'h0)
      else $error("low address reads low bits set");
   a_msg_aligned: assert property (
      msg_valid |-> msg.address[1:0] == 2'h0)
      else $error("message address not aligned");
   a_msg_narrow: assert property (
      msg_valid |-> msg.data[31:16] == 16'h0000)
      else $error("message data upper half set");
   a_msg_hold: assert property (
      msg_valid && !msg_ready |=> msg_valid && $stable(msg))
      else $error("message changed before taken");
   a_msg_single: assert property (
      msg_valid && msg_ready |=> !msg_valid)
      else $error("second message without new event");
   a_read_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_read_unmapped: assert property (
      s_axi_rvalid && last_ar > 12'h0F4 |-> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0000_0000)
      else $error("unmapped read not refused");
   a_read_hold: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
endmodule
bind event_msg_regs event_msg_regs_sva sva (.aclk(aclk), .aresetn(aresetn),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .msg(msg),
   .msg_valid(msg_valid), .msg_ready(msg_ready));

// ---- event_msg_regs_tb_top.sv ----
/* bench: axi4-lite tasks, message sink, one task per scenario.
   assumes package, design, sink and checker compiled first. */
`timescale 1ns/1ps
module event_msg_regs_tb_top;
   logic                    aclk = 1'h0, aresetn = 1'h0, page_event = 1'h0;
   logic                    awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   logic                    arvalid = 1'h0, rready = 1'h0, awready, wready;
   logic                    bvalid, arready, rvalid, msg_valid, msg_ready, irq;
   logic [11:0]             awaddr = 12'h000, araddr = 12'h000;
   logic [31:0]             wdata = 32'h0000_0000, rdata, rd;
   logic [3:0]              wstrb = 4'hF, stall = 4'h0;
   logic [1:0]              bresp, rresp, rsp;
   logic [7:0]              taken;
   event_msg_pkg::message_s msg, got;
   logic [31:0]             plain_rdata, rd_plain;
   int                      mismatches = 0, checks_done = 0;
   // 100 MHz clock
   always #5 aclk = ~aclk;
   event_msg_regs dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .page_event(page_event), .msg(msg),
      .msg_valid(msg_valid), .msg_ready(msg_ready), .irq(irq));
   event_msg_sink sink (.aclk(aclk), .aresetn(aresetn), .msg(msg),
      .msg_valid(msg_valid), .stall(stall), .msg_ready(msg_ready), .got(got), .taken(taken));
   // second copy without page request support or extended mode; bus timing matches dut
   event_msg_regs #(.page_request_supported(1'b0), .extended_mode_supported(1'b0),
      .wide_data_supported(1'b0)) plain (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(),
      .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(), .s_axi_rdata(plain_rdata),
      .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(rready), .page_event(page_event),
      .msg(), .msg_valid(), .msg_ready(1'h0), .irq());
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      if (seen !== exp)
         mismatches++;
   endtask
   // one bus transfer; ready sampled at the falling edge avoids racing the slave
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
      logic go, aw_go, w_go, ar_go;
      go = 1'h0;
      @(posedge aclk);
      awaddr <= a;
      araddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= w;
      wvalid <= w;
      bready <= w;
      arvalid <= !w;
      rready <= !w;
      for (int n = 0; n < 50 && !go; n++)
      begin
         @(negedge aclk);
         go = w ? bvalid : rvalid;
         aw_go = awready;
         w_go = wready;
         ar_go = arready;
         rd = rdata;
         rd_plain = plain_rdata;
         rsp = w ? bresp : rresp;
         @(posedge aclk);
         if (aw_go)
            awvalid <= 1'h0;
         if (w_go)
            wvalid <= 1'h0;
         if (ar_go)
            arvalid <= 1'h0;
      end
      bready <= 1'h0;
      rready <= 1'h0;
      chk(go, 1'h1);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      xfer(1'h1, a, d, 4'hF);
   endtask
   task automatic rd_reg(input logic [11:0] a);
      xfer(1'h0, a, 32'h0000_0000, 4'h0);
   endtask
   task automatic pulse;
      @(posedge aclk);
      page_event <= 1'h1;
      @(posedge aclk);
      page_event <= 1'h0;
   endtask
   task automatic wait_taken(input logic [7:0] n);
      for (int i = 0; i < 30 && taken !== n; i++)
         @(negedge aclk);
      chk(taken, n);
   endtask
   task automatic t_regs;
      rd_reg(12'h0E0);
      chk(rd, 32'h8000_0000);
      rd_reg(12'h0E4);
      chk(rd, 32'h0000_0000);
      rd_reg(12'h0E8);
      chk(rd, 32'h0000_0000);
      rd_reg(12'h0EC);
      chk(rd, 32'h0000_0000);
      wr(12'h0E8, 32'hFFFF_FFFF);
      chk(rsp, 2'h0);
      rd_reg(12'h0E8);
      chk(rd, 32'hFFFF_FFFC);
      chk(rd_plain, 32'h0000_0000);
      wr(12'h0EC, 32'hA5C3_0F1E);
      xfer(1'h1, 12'h0EC, 32'h1234_5678, 4'h3);
      rd_reg(12'h0EC);
      chk(rd, 32'hA5C3_5678);
      chk(rd_plain, 32'h0000_0000);
      wr(12'h0F8, 32'h0000_0001);
      chk(rsp, 2'h2);
      rd_reg(12'h0F8);
      chk(rd, 32'h0000_0000);
      chk(rsp, 2'h2);
      $display("register test done");
   endtask
   task automatic t_msg;
      wr(12'h0E4, 32'hABCD_1234);
      wr(12'h0E8, 32'h8765_4323);
      wr(12'h0EC, 32'h0000_00FE);
      wr(12'h0F4, 32'h0000_0001);
      wr(12'h0E0, 32'h0000_0000);
      pulse;
      wait_taken(8'h01);
      chk(got.address[63:32], 32'h0000_00FE);
      chk(got.address[31:0], 32'h8765_4320);
      chk(got.data, 32'h0000_1234);
      chk(irq, 1'h1);
      rd_reg(12'h0F0);
      chk(rd, 32'h0000_0001);
      @(negedge aclk);
      chk(irq, 1'h0);
      $display("message test done");
   endtask
   task automatic t_masked;
      stall <= 4'h3;
      wr(12'h0F4, 32'h0000_0000);
      wr(12'h0E0, 32'h8000_0000);
      wr(12'h0E8, 32'h0000_1001);
      pulse;
      repeat (30) @(negedge aclk);
      chk(taken, 8'h01);
      rd_reg(12'h0E0);
      chk(rd, 32'hC000_0000);
      wr(12'h0E0, 32'h0000_0000);
      wait_taken(8'h02);
      chk(got.address[31:0], 32'h0000_1000);
      chk(irq, 1'h0);
      rd_reg(12'h0F0);
      chk(rd, 32'h0000_0001);
      $display("masked test done");
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // main sequence after five reset cycles
   initial
   begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'h1;
      t_regs;
      t_msg;
      t_masked;
      final_report;
   end
   // watchdog: the tests need well under a thousand cycles
   initial
   begin
      repeat (5000) @(posedge aclk);
      mismatches++;
      final_report;
   end
endmodule

// ---- event_msg_sink.sv ----
/* far-side model: interrupt fabric sink taking event messages after a stall.
   assumes the bench sets the stall count between messages. */
`timescale 1ns/1ps
module event_msg_sink
(
   input  wire logic                    aclk,
   input  wire logic                    aresetn,
   input  wire event_msg_pkg::message_s msg,
   input  wire logic                    msg_valid,
   input  wire logic [3:0]              stall,
   output logic                         msg_ready,
   output event_msg_pkg::message_s      got,
   output logic [7:0]                   taken
);
   logic [3:0] waited;
   // ready only after the stall, so a slow fabric is tried too
   assign msg_ready = msg_valid && (waited >= stall);
   // take, count and keep each message
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         waited <= 4'h0;
         taken  <= 8'h00;
         got    <= '0;
      end
      else if (msg_ready)
      begin
         waited <= 4'h0;
         taken  <= taken + 8'h01;
         got    <= msg;
      end
      else if (msg_valid)
         waited <= waited + 4'h1;
   end
endmodule

// ---- reg_word.sv ----
/*
 holds one 32-bit software register with a per-bit writable mask.
 assumes writes come already decoded and strobed from the bus slave.
*/
`timescale 1ns/1ps
module reg_word
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        write_en,
   input  wire logic [3:0]  write_strb,
   input  wire logic [31:0] write_data,
   input  wire logic [31:0] keep_mask,
   input  wire logic [31:0] reset_value,
   output logic      [31:0] value
);
   logic [31:0] strb_mask;
   logic [31:0] next_value;

   // ------------------------------------------------------------
   // byte lane merge
   // ------------------------------------------------------------
   genvar lane;
   generate
      for (lane = 0; lane < 4; lane++)
      begin : g_lane
         assign strb_mask[lane*8 +: 8] = {8{write_strb[lane]}};
      end
   endgenerate
   // bits outside keep_mask stay at zero whatever is written
   assign next_value = ((value & ~strb_mask) | (write_data & strb_mask)) & keep_mask;

   // register update
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         value <= reset_value;
      else if (write_en)
         value <= next_value;
   end
endmodule
